//--- logic/reset_cause_defs.vh
// constants for the reset cause flag block
`ifndef RESET_CAUSE_DEFS_VH
`define RESET_CAUSE_DEFS_VH

// ******************************
// register byte offsets
// ******************************
`define OFS_CAUSE_A      12'h000
`define OFS_START_TYPE   12'h004
`define OFS_CAUSE_B      12'h008
`define OFS_EVT_STATUS   12'h00c
`define OFS_EVT_ENABLE   12'h010
`define OFS_EVT_CLEAR    12'h014
`define OFS_SRC_LEVEL    12'h018

// ******************************
// field positions
// ******************************
`define BIT_POWER_ON     0
`define BIT_VMON0        1
`define BIT_VMON1        2
`define BIT_VMON2        3
`define BIT_DEEP_STBY    7
`define BIT_COLD_WARM    0
`define BIT_IND_WDOG     0
`define BIT_WDOG         1
`define BIT_SOFT         2

// event and source bit order: pin, power-on, vmon0, watchdog
`define EV_PIN           0
`define EV_POR           1
`define EV_VMON0         2
`define EV_WDOG          3
`define EV_WIDTH         4

// ******************************
// reset values and widths
// ******************************
`define FLAG_CLR         1'b0
`define FLAG_SET         1'b1
`define REG8_ZERO        8'h00
`define EV_ZERO          4'h0
`define WORD_ZERO        32'h0000_0000
`define ADDR_W           12

`endif

//--- logic/level_sync.v
// two-stage synchroniser for asynchronous level inputs
module level_sync #(
  parameter WIDTH = 4
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_one;

  // first stage feeds only the second
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_one <= {WIDTH{1'b0}};
      sync_out  <= {WIDTH{1'b0}};
    end
    else
    begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule

//--- logic/reset_cause_flags.v
// reset cause detect flags, cold/warm start flag and apb register file
//
// Decided for this implementation: the APB register port and the register addresses.
`include "reset_cause_defs.vh"

module reset_cause_flags (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // asynchronous reset sources
  input  wire        external_reset_pin_n,
  input  wire        power_on_req,
  input  wire        voltage_mon0_req,
  input  wire        watchdog_req,
  // status outputs
  output reg         reset_active,
  output reg         irq
);

  // ******************************
  // source synchronisation
  // ******************************
  wire [`EV_WIDTH-2:0] src_raw;
  wire [`EV_WIDTH-2:0] src_high;
  wire [`EV_WIDTH-1:0] src;
  reg  [`EV_WIDTH-1:0] src_prev;
  wire [`EV_WIDTH-1:0] src_rise;
  reg                  pin_meta;
  reg                  pin_sync;

  // active-high sources: power-on, monitor 0, watchdog
  assign src_raw = {watchdog_req, voltage_mon0_req, power_on_req};

  level_sync #(
    .WIDTH (`EV_WIDTH-1)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (src_raw),
    .sync_out (src_high)
  );

  // pin stages preset high so leaving presetn never looks like a pin reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= `FLAG_SET;
      pin_sync <= `FLAG_SET;
    end
    else
    begin
      pin_meta <= external_reset_pin_n;
      pin_sync <= pin_meta;
    end
  end

  // pin inverted only after both stages, so all levels read active high
  assign src      = {src_high, ~pin_sync};
  assign src_rise = src & ~src_prev;

  // ******************************
  // flag registers
  // ******************************
  reg power_on_detect_flag;
  reg voltage_mon0_detect_flag;
  reg watchdog_detect_flag;
  reg cold_warm_start_flag;
  reg next_power_on;
  reg next_vmon0;
  reg next_wdog;
  reg next_cold_warm;

  // other causes are not sourced here; they read as cleared
  wire voltage_mon1_detect_flag         = `FLAG_CLR;
  wire voltage_mon2_detect_flag         = `FLAG_CLR;
  wire deep_standby_cancel_flag         = `FLAG_CLR;
  wire independent_watchdog_detect_flag = `FLAG_CLR;
  wire software_reset_detect_flag       = `FLAG_CLR;

  // ******************************
  // apb decode
  // ******************************
  wire access   = psel & penable & ~pready;
  wire wr_take  = psel & penable & pready & pwrite;
  wire any_src  = |src;

  function hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  function mapped;
    input [`ADDR_W-1:0] addr;
    begin
      mapped = hit(addr, `OFS_CAUSE_A) |
               hit(addr, `OFS_START_TYPE) |
               hit(addr, `OFS_CAUSE_B) |
               hit(addr, `OFS_EVT_STATUS) |
               hit(addr, `OFS_EVT_ENABLE) |
               hit(addr, `OFS_EVT_CLEAR) |
               hit(addr, `OFS_SRC_LEVEL);
    end
  endfunction

  wire wr_cause_a = wr_take & hit(paddr, `OFS_CAUSE_A);
  wire wr_start   = wr_take & hit(paddr, `OFS_START_TYPE);
  wire wr_cause_b = wr_take & hit(paddr, `OFS_CAUSE_B);
  wire wr_enable  = wr_take & hit(paddr, `OFS_EVT_ENABLE);
  wire wr_clear   = wr_take & hit(paddr, `OFS_EVT_CLEAR);

  // ******************************
  // flag update, highest source last
  // ******************************
  always @*
  begin
    next_power_on  = power_on_detect_flag;
    next_vmon0     = voltage_mon0_detect_flag;
    next_wdog      = watchdog_detect_flag;
    next_cold_warm = cold_warm_start_flag;
    // software clears a cause flag by writing zero; warm start marked by one
    if (wr_cause_a && !pwdata[`BIT_POWER_ON])
    begin
      next_power_on = `FLAG_CLR;
    end
    if (wr_cause_a && !pwdata[`BIT_VMON0])
    begin
      next_vmon0 = `FLAG_CLR;
    end
    if (wr_cause_b && !pwdata[`BIT_WDOG])
    begin
      next_wdog = `FLAG_CLR;
    end
    if (wr_start && pwdata[`BIT_COLD_WARM])
    begin
      next_cold_warm = `FLAG_SET;
    end
    // watchdog touches neither power-on, monitor 0 nor cold/warm
    if (src[`EV_WDOG])
    begin
      next_wdog = `FLAG_SET;
    end
    // monitor 0 keeps power-on and cold/warm
    if (src[`EV_VMON0])
    begin
      next_vmon0 = `FLAG_SET;
      next_wdog  = `FLAG_CLR;
    end
    // pin keeps cold/warm only
    if (src[`EV_PIN])
    begin
      next_power_on = `FLAG_CLR;
      next_vmon0    = `FLAG_CLR;
      next_wdog     = `FLAG_CLR;
    end
    // power-on wins over every other source
    if (src[`EV_POR])
    begin
      next_power_on  = `FLAG_SET;
      next_vmon0     = `FLAG_CLR;
      next_wdog      = `FLAG_CLR;
      next_cold_warm = `FLAG_CLR;
    end
  end

  // flags keep their value after release since no source drives them then
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_on_detect_flag     <= `FLAG_CLR;
      voltage_mon0_detect_flag <= `FLAG_CLR;
      watchdog_detect_flag     <= `FLAG_CLR;
      cold_warm_start_flag     <= `FLAG_CLR;
    end
    else
    begin
      power_on_detect_flag     <= next_power_on;
      voltage_mon0_detect_flag <= next_vmon0;
      watchdog_detect_flag     <= next_wdog;
      cold_warm_start_flag     <= next_cold_warm;
    end
  end

  // ******************************
  // source history and activity
  // ******************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_prev     <= `EV_ZERO;
      reset_active <= `FLAG_CLR;
    end
    else
    begin
      src_prev     <= src;
      reset_active <= any_src;
    end
  end

  // ******************************
  // event interrupt
  // ******************************
  reg [`EV_WIDTH-1:0] evt_status;
  reg [`EV_WIDTH-1:0] evt_enable;

  // a rising source in the clearing cycle survives the clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_status <= `EV_ZERO;
      evt_enable <= `EV_ZERO;
      irq        <= `FLAG_CLR;
    end
    else
    begin
      evt_status <= (evt_status & ~(wr_clear ? pwdata[`EV_WIDTH-1:0] : `EV_ZERO)) | src_rise;
      if (wr_enable)
      begin
        evt_enable <= pwdata[`EV_WIDTH-1:0];
      end
      irq <= |(evt_status & evt_enable);
    end
  end

  // ******************************
  // read mux
  // ******************************
  reg [31:0] rd_word;
  wire [7:0] cause_a_word = {deep_standby_cancel_flag, 3'h0, voltage_mon2_detect_flag,
                             voltage_mon1_detect_flag, voltage_mon0_detect_flag,
                             power_on_detect_flag};
  wire [7:0] cause_b_word = {5'h00, software_reset_detect_flag, watchdog_detect_flag,
                             independent_watchdog_detect_flag};
  wire [7:0] start_word   = {7'h00, cold_warm_start_flag};

  always @*
  begin
    rd_word = `WORD_ZERO;
    if (hit(paddr, `OFS_CAUSE_A))
      rd_word = {24'h000000, cause_a_word};
    else if (hit(paddr, `OFS_START_TYPE))
      rd_word = {24'h000000, start_word};
    else if (hit(paddr, `OFS_CAUSE_B))
      rd_word = {24'h000000, cause_b_word};
    else if (hit(paddr, `OFS_EVT_STATUS))
      rd_word = {28'h0000000, evt_status};
    else if (hit(paddr, `OFS_EVT_ENABLE))
      rd_word = {28'h0000000, evt_enable};
    else if (hit(paddr, `OFS_SRC_LEVEL))
      rd_word = {28'h0000000, src};
  end

  // ******************************
  // apb handshake: one wait state
  // ******************************
  // a registered answer keeps prdata off the combinational decode path
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= `FLAG_CLR;
      pslverr <= `FLAG_CLR;
      prdata  <= `WORD_ZERO;
    end
    else
    begin
      pready  <= access;
      pslverr <= access & ~mapped(paddr);
      if (access && !pwrite)
      begin
        prdata <= rd_word;
      end
      else
      begin
        prdata <= `WORD_ZERO;
      end
    end
  end

endmodule

//--- verification/reset_cause_checks_assertions.sv
// assertion checker for the reset cause flag block
module reset_cause_checks (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // sources
  input wire        external_reset_pin_n,
  input wire        power_on_req,
  input wire        voltage_mon0_req,
  input wire        watchdog_req,
  input wire        reset_active
);
  // ********
  // last source: 1 pin 2 por 3 vmon0 4 wdog
  // ********
  logic [2:0] last_src;
  wire        rd = pready && !pwrite;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      last_src <= 3'h0;
    else if (!external_reset_pin_n)
      last_src <= 3'h1;
    else if (power_on_req)
      last_src <= 3'h2;
    else if (voltage_mon0_req)
      last_src <= 3'h3;
    else if (watchdog_req)
      last_src <= 3'h4;
    // a completed write may change any flag, so stop predicting
    else if (pready && pwrite)
      last_src <= 3'h0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_follows: assert property (psel && penable && !pready |=> pready)
    else $error("no pready");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("long pready");
  chk_err_unmapped: assert property (pready && paddr > 12'h018 |-> pslverr)
    else $error("no pslverr");
  chk_src_active: assert property (watchdog_req [*4] |-> reset_active)
    else $error("reset_active low");
  chk_pin_clears: assert property (rd && paddr == 12'h0 && last_src == 3'h1 |-> prdata[1:0] == 2'h0)
    else $error("pin left flags");
  chk_vmon_sets: assert property (rd && paddr == 12'h0 && last_src == 3'h3 |-> prdata[1])
    else $error("vmon0 flag low");
  chk_wdog_cleared: assert property (rd && paddr == 12'h8 && last_src inside {[1:3]} |-> !prdata[1])
    else $error("wdog flag kept");
  chk_por_sets: assert property (rd && paddr == 12'h0 && last_src == 3'h2 |-> prdata[1:0] == 2'h1)
    else $error("por flags wrong");
  chk_cold_cleared: assert property (rd && paddr == 12'h4 && last_src == 3'h2 |-> !prdata[0])
    else $error("cold/warm kept");
  chk_wdog_sets: assert property (rd && paddr == 12'h8 && last_src == 3'h4 |-> prdata[1])
    else $error("wdog flag low");
  cover property (pready && pslverr);
  cover property (!external_reset_pin_n);
  cover property (reset_active);
endmodule
bind reset_cause_flags reset_cause_checks i_checks (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .external_reset_pin_n(external_reset_pin_n), .power_on_req(power_on_req),
  .voltage_mon0_req(voltage_mon0_req), .watchdog_req(watchdog_req), .reset_active(reset_active));

//--- verification/reset_cause_flags_test.sv
// testbench for the reset cause flag block
module reset_cause_flags_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // stimulus and scoreboard
  // ********
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  src = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        reset_active;
  logic        irq;
  logic [7:0]  seed = 8'h4f;
  logic [44:0] exp_q[$];
  logic [44:0] e;
  int          failures = 0;
  int          check_count = 0;
  int          first_src[4] = '{3, 3, 2, 3};
  int          second_src[4] = '{0, 2, 0, 1};
  logic [7:0]  exp_a[4] = '{8'h00, 8'h02, 8'h00, 8'h01};
  logic        exp_cw[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  always #50 pclk = ~pclk;
  reset_cause_flags i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_reset_pin_n(~src[0]), .power_on_req(src[1]),
    .voltage_mon0_req(src[2]), .watchdog_req(src[3]), .reset_active(reset_active), .irq(irq));
  function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task report(input string nm, input logic [32:0] x, input logic [32:0] got);
    check_count++;
    if (got !== x)
    begin
      failures++;
      $display("BAD %s exp %h got %h", nm, x, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench watchdog ends a slave that never answers
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [32:0] x);
    exp_q.push_back({a, x});
    apb(1'b0, a, 32'h0);
  endtask
  // random hold length keeps the synchroniser honest
  task pulse(input int i);
    seed = lfsr(seed);
    @(posedge pclk);
    src[i] <= 1'b1;
    repeat (4 + seed[2:0]) @(posedge pclk);
    report("reset_active", 33'h1, {32'h0, reset_active});
    rd(12'h018, 33'h1 << i);
    src[i] <= 1'b0;
    repeat (6) @(posedge pclk);
    report("reset_active idle", 33'h0, {32'h0, reset_active});
  endtask
  always @(posedge pclk)
    if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      report($sformatf("read %h", e[44:33]), e[32:0], {pslverr, prdata});
    end
  task print_verdict;
    // a read that never answered leaves its note behind
    if (exp_q.size() > 0)
      failures++;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ********
  // main sequence
  // ********
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 33'h0);
    rd(12'h004, 33'h0);
    apb(1'b1, 12'h004, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      pulse(first_src[k]);
      if (first_src[k] == 3)
        rd(12'h008, 33'h2);
      pulse(second_src[k]);
      rd(12'h000, {25'h0, exp_a[k]});
      rd(12'h004, {32'h0, exp_cw[k]});
      rd(12'h008, 33'h0);
      $display("scenario %0d done", k);
    end
    pulse(3);
    rd(12'h000, 33'h1);
    rd(12'h008, 33'h2);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    rd(12'h000, 33'h0);
    rd(12'h008, 33'h0);
    rd(12'h00c, 33'hf);
    report("irq masked", 33'h0, {32'h0, irq});
    apb(1'b1, 12'h010, 32'hf);
    repeat (3) @(posedge pclk);
    report("irq", 33'h1, {32'h0, irq});
    apb(1'b1, 12'h014, 32'hf);
    rd(12'h00c, 33'h0);
    rd(12'h010, 33'hf);
    rd(12'h014, 33'h0);
    rd(12'h020, 33'h1_0000_0000);
    report("irq cleared", 33'h0, {32'h0, irq});
    apb(1'b1, 12'h010, {28'h0, seed[3:0]});
    rd(12'h010, {29'h0, seed[3:0]});
    rd(12'h018, 33'h0);
    repeat (2) @(posedge pclk);
    $display("irq and map done");
    print_verdict;
  end
  initial
  begin
    repeat (5000) @(posedge pclk);
    failures++;
    print_verdict;
  end
endmodule
